// File: hdl/ddr_cmd_host.sv
// Memory command host: APB registers, memory clock divider, command sequencer
// Operation
// (RL1) Command follows chip select by latency
// (RL2) Device may idle receivers after command
// (RL3) Back-to-back commands keep receivers on
// (RL4) Wait update delay plus latency after MRS
// (RL5) Space mode sets by delay plus latency
// (RL6) Spacing uses newly programmed latency
// (RL7) Both temp bits select automatic self refresh
// (RL8) Temp bits decode four self refresh modes
// (RL9) Temp mode changes only outside self refresh
// (RL10) NOP exit needs parity and latency off
// (RL11) Only NOPs during exit window
// (RL12) NOP is chip select low, rest high
// (RL13) Four pages of four byte registers
// (RL14) Banks precharged before access mode set
// (RL15) No bus inversion during register reads
// (RL16) Reads go to selected register location
// (RL17) Access mode allows few commands only
// (RL18) Location from read address, halves
// (RL19) No power-down or self refresh there
// (RL20) Only 1x refresh, wait refresh time
// (RL21) Finish reads/writes before refresh
// (RL22) Reset allowed in access mode
// (RL23) Reads only burst 8 or chop 4
// (RL24) Page 0 patterns kept until reinit
// (RL25) Page 2 returns mode registers
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module ddr_cmd_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic ck,
    output logic cke,
    output logic cs_n,
    output logic act_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [ddr_host_pkg::ADDR_W-1:0] addr,
    output logic [1:0] ba,
    output logic [1:0] bg,
    output logic reset_n
);
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_WAIT} seq_e;

    // Latency code to clock cycles, zero means latency off
    function automatic logic [3:0] cal_cycles(input logic [2:0] code);
        case (code)
            3'h1: cal_cycles = 4'h3;
            3'h2: cal_cycles = 4'h4;
            3'h3: cal_cycles = 4'h5;
            3'h4: cal_cycles = 4'h6;
            3'h5: cal_cycles = 4'h8;
            default: cal_cycles = 4'h0;
        endcase
    endfunction

    // Command pins {act_n, ras_n, cas_n, we_n} for an opcode
    function automatic logic [3:0] cmd_pins(input logic [3:0] op);
        case (op)
            ddr_host_pkg::OP_MRS: cmd_pins = 4'h8;
            ddr_host_pkg::OP_REF, ddr_host_pkg::OP_SRE: cmd_pins = 4'h9;
            ddr_host_pkg::OP_PRE_ALL: cmd_pins = 4'hA;
            ddr_host_pkg::OP_ACT: cmd_pins = 4'h7;
            ddr_host_pkg::OP_RD: cmd_pins = 4'hD;
            ddr_host_pkg::OP_WR: cmd_pins = 4'hC;
            default: cmd_pins = 4'hF;
        endcase
    endfunction

    // Software registers and tracked device state
    logic [3:0] op; // Pending opcode
    logic [31:0] addr_reg; // Address word for next command
    logic pending; // Command waiting for the sequencer
    logic refused; // Sticky: a command was refused, as illegal or written while busy
    logic [2:0] cal_code; // Shadow of programmed latency
    logic [1:0] temp_mode; // Shadow of self refresh temperature mode
    logic [2:0] parity_code; // Shadow of parity setting
    logic mpx; // Multipurpose register access mode on
    logic in_sr; // Device in self refresh
    logic in_pd; // Device in power-down
    logic sr_nop_exit; // Captured at entry: NOP exit allowed
    logic banks_open; // Some bank activated since last precharge
    logic nop_win; // Inside exit window, NOPs only
    seq_e state;
    logic [ddr_host_pkg::CNT_W-1:0] cnt; // Lead or spacing counter
    logic [1:0] div_cnt; // Memory clock divider

    // APB decode
    wire apb_acc = psel && penable && pready;
    wire wr_cmd = apb_acc && pwrite && paddr == ddr_host_pkg::REG_CMD;
    wire wr_addr = apb_acc && pwrite && paddr == ddr_host_pkg::REG_ADDR;
    wire wr_stat = apb_acc && pwrite && paddr == ddr_host_pkg::REG_STATUS;
    wire mapped = paddr == ddr_host_pkg::REG_CMD || paddr == ddr_host_pkg::REG_ADDR
        || paddr == ddr_host_pkg::REG_STATUS;
    wire busy = pending || state != ST_IDLE;

    // Memory clock edges: sequencer moves pins while ck is low-going
    wire div_end = div_cnt == 2'(ddr_host_pkg::CK_HALF - 1);
    wire ck_fall = div_end && ck;

    // Fields of the pending command
    wire [2:0] mr_sel = {addr_reg[ddr_host_pkg::BG_LSB], addr_reg[ddr_host_pkg::BA_LSB +: 2]};
    wire is_mrs = op == ddr_host_pkg::OP_MRS;
    wire mrs_lat = is_mrs && mr_sel == ddr_host_pkg::MR_LAT;
    wire mrs_temp = is_mrs && mr_sel == ddr_host_pkg::MR_TEMP;
    wire mrs_acc = is_mrs && mr_sel == ddr_host_pkg::MR_ACCESS;
    wire mrs_par = is_mrs && mr_sel == ddr_host_pkg::MR_PARITY;
    wire mrs_bl = is_mrs && mr_sel == ddr_host_pkg::MR_BURST;
    wire [2:0] new_cal = mrs_lat ? addr_reg[ddr_host_pkg::CAL_LSB +: 3] : cal_code; // RL6
    wire cal_on = cal_code != 3'h0;
    wire cke_only = op == ddr_host_pkg::OP_SRX || op == ddr_host_pkg::OP_PDX
        || op == ddr_host_pkg::OP_RESET;
    wire use_lead = cal_on && !cke_only; // RL1
    wire [2:0] col = addr_reg[2:0];

    // Legal commands while in access mode
    wire mpx_legal = op == ddr_host_pkg::OP_MRS || op == ddr_host_pkg::OP_RD
        || op == ddr_host_pkg::OP_WR || op == ddr_host_pkg::OP_DES
        || op == ddr_host_pkg::OP_REF || op == ddr_host_pkg::OP_RESET; // RL17 RL19 RL22
    wire mpx_bad = mpx && (!mpx_legal // RL17 RL19
        || (op == ddr_host_pkg::OP_RD && col != ddr_host_pkg::BURST8_COL
            && col != ddr_host_pkg::CHOP4_COL) // RL23
        || (mrs_bl && addr_reg[ddr_host_pkg::BL_LSB +: 2] == ddr_host_pkg::BL_ON_THE_FLY) // RL23
        || (mrs_par && addr_reg[ddr_host_pkg::DBI_RD_BIT]) // RL15
        || (mrs_acc && addr_reg[ddr_host_pkg::FGR_LSB +: 3] != 3'h0)); // RL20
    wire prech_bad = mrs_acc && addr_reg[ddr_host_pkg::MPX_BIT] && banks_open; // RL14
    // Self refresh locks the mode; only exit or reset is taken there
    wire sr_bad = in_sr ? op != ddr_host_pkg::OP_SRX && op != ddr_host_pkg::OP_RESET
        : op == ddr_host_pkg::OP_SRX; // RL9
    wire pd_bad = in_pd ? op != ddr_host_pkg::OP_PDX && op != ddr_host_pkg::OP_RESET
        : op == ddr_host_pkg::OP_PDX;
    wire refuse = op != ddr_host_pkg::OP_RESET && (mpx_bad || prech_bad || sr_bad || pd_bad);

    // Acceptance and the cycle where command pins are driven
    wire go = ck_fall && state == ST_IDLE && pending;
    wire accept = go && !refuse;
    wire issue = (accept && !use_lead) || (ck_fall && state == ST_LEAD && cnt == '0);

    // Spacing after the command, in memory clock cycles
    wire [3:0] new_lat = cal_cycles(new_cal);
    wire [ddr_host_pkg::CNT_W-1:0] mrs_space =
        ddr_host_pkg::CNT_W'(ddr_host_pkg::TMOD_CK) + ddr_host_pkg::CNT_W'(new_lat); // RL4 RL5
    logic [ddr_host_pkg::CNT_W-1:0] space;
    always_comb begin
        case (op)
            ddr_host_pkg::OP_MRS: space = mrs_space;
            ddr_host_pkg::OP_REF: space = ddr_host_pkg::CNT_W'(ddr_host_pkg::TRFC_CK); // RL20
            ddr_host_pkg::OP_PRE_ALL: space = ddr_host_pkg::CNT_W'(ddr_host_pkg::TRP_CK);
            ddr_host_pkg::OP_RD, ddr_host_pkg::OP_WR:
                space = ddr_host_pkg::CNT_W'(ddr_host_pkg::BURST_CK); // RL21
            ddr_host_pkg::OP_SRX: space = ddr_host_pkg::CNT_W'(ddr_host_pkg::EXIT_WIN_CK);
            ddr_host_pkg::OP_RESET: space = ddr_host_pkg::CNT_W'(ddr_host_pkg::RESET_CK);
            default: space = ddr_host_pkg::CNT_W'(1);
        endcase
    end

    // Status word
    wire [31:0] status = {16'h0, 1'b0, cal_code, 2'h0, temp_mode, 2'h0, banks_open,
        in_pd, in_sr, mpx, refused, busy};

    // APB answer: one wait state, then data and error together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata <= (psel && !pwrite && paddr == ddr_host_pkg::REG_STATUS) ? status : 32'h0;
        end
    end

    // Software writes; a command written while busy is refused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op <= 4'h0;
            addr_reg <= 32'h0;
            pending <= 1'b0;
            refused <= 1'b0;
        end else begin
            if (wr_addr)
                addr_reg <= pwdata;
            if (wr_cmd && !busy) begin
                op <= pwdata[ddr_host_pkg::OP_W-1:0];
                pending <= 1'b1;
            end else if (go) begin
                pending <= 1'b0;
            end
            // Set wins over the write-one clear
            if ((go && refuse) || (wr_cmd && busy))
                refused <= 1'b1;
            else if (wr_stat && pwdata[ddr_host_pkg::ST_REFUSED])
                refused <= 1'b0;
        end
    end

    // Memory clock divider, driven out as ck
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 2'h0;
            ck <= 1'b0;
        end else begin
            div_cnt <= div_end ? 2'h0 : div_cnt + 2'h1;
            if (div_end)
                ck <= !ck;
        end
    end

    // Sequencer: latency lead, command drive, spacing wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            cnt <= '0;
        end else if (ck_fall) begin
            case (state)
                ST_IDLE: begin
                    if (accept && use_lead) begin
                        state <= ST_LEAD;
                        cnt <= ddr_host_pkg::CNT_W'(cal_cycles(cal_code) - 4'h1); // RL1
                    end else if (accept) begin
                        state <= ST_WAIT;
                        cnt <= space;
                    end
                end
                ST_LEAD: begin
                    if (cnt == '0) begin
                        state <= ST_WAIT;
                        cnt <= space;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (cnt == ddr_host_pkg::CNT_W'(1))
                        state <= ST_IDLE;
                    cnt <= cnt - 1'b1;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Command and address pins; chip select on the lead cycle if latency is on, else with the command save reset and non-NOP exits, and for exit window NOPs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_n <= 1'b1;
            {act_n, ras_n, cas_n, we_n} <= 4'hF;
            addr <= '0;
            ba <= 2'h0;
            bg <= 2'h0;
        end else if (ck_fall) begin
            if (accept && use_lead) begin
                cs_n <= 1'b0; // RL1
                {act_n, ras_n, cas_n, we_n} <= 4'hF;
            end else if (issue) begin
                // Exit by NOP and commands without latency take chip select low; commands after a latency lead, other exits and reset deselect
                cs_n <= use_lead || (cke_only && !(op == ddr_host_pkg::OP_SRX && sr_nop_exit));
                {act_n, ras_n, cas_n, we_n} <= cmd_pins(op); // RL12
                addr <= addr_reg[ddr_host_pkg::ADDR_W-1:0];
                ba <= addr_reg[ddr_host_pkg::BA_LSB +: 2];
                bg <= addr_reg[ddr_host_pkg::BG_LSB +: 2];
            end else begin
                cs_n <= !nop_win || state != ST_WAIT || cnt == ddr_host_pkg::CNT_W'(1); // RL11
                {act_n, ras_n, cas_n, we_n} <= 4'hF;
            end
        end
    end

    // Clock enable, reset pin and shadows of the device mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cke <= 1'b1;
            reset_n <= 1'b1;
            cal_code <= 3'h0;
            temp_mode <= 2'h0;
            parity_code <= 3'h0;
            mpx <= 1'b0;
            in_sr <= 1'b0;
            in_pd <= 1'b0;
            sr_nop_exit <= 1'b0;
            banks_open <= 1'b0;
            nop_win <= 1'b0;
        end else if (ck_fall) begin
            if (state == ST_WAIT && cnt == ddr_host_pkg::CNT_W'(1)) begin
                reset_n <= 1'b1;
                nop_win <= 1'b0;
            end
            if (issue) begin
                case (op)
                    ddr_host_pkg::OP_MRS: begin
                        cal_code <= new_cal; // RL6
                        if (mrs_temp)
                            temp_mode <= addr_reg[ddr_host_pkg::TEMP_LSB +: 2]; // RL7 RL8
                        if (mrs_par)
                            parity_code <= addr_reg[ddr_host_pkg::PAR_LSB +: 3];
                        if (mrs_acc)
                            mpx <= addr_reg[ddr_host_pkg::MPX_BIT];
                    end
                    ddr_host_pkg::OP_ACT: banks_open <= 1'b1;
                    ddr_host_pkg::OP_PRE_ALL: banks_open <= 1'b0;
                    ddr_host_pkg::OP_SRE: begin
                        cke <= 1'b0;
                        in_sr <= 1'b1; // RL9
                        sr_nop_exit <= parity_code == 3'h0 && !cal_on; // RL10
                    end
                    ddr_host_pkg::OP_SRX: begin
                        cke <= 1'b1;
                        in_sr <= 1'b0;
                        nop_win <= sr_nop_exit; // RL11
                    end
                    ddr_host_pkg::OP_PDE: begin
                        cke <= 1'b0;
                        in_pd <= 1'b1;
                    end
                    ddr_host_pkg::OP_PDX: begin
                        cke <= 1'b1;
                        in_pd <= 1'b0;
                    end
                    ddr_host_pkg::OP_RESET: begin
                        // Device needs full initialization afterwards
                        reset_n <= 1'b0; // RL22
                        cke <= 1'b0;
                        {cal_code, temp_mode, parity_code} <= 8'h00;
                        {mpx, in_sr, in_pd, banks_open} <= 4'h0;
                    end
                    default: cke <= cke;
                endcase
            end
        end
    end

    // Checks on the driven command stream and the APB answer
    AST_CAL_LEAD: assert property (@(posedge pclk) disable iff (!presetn) // RL1
        (ck_fall && accept && use_lead) |=> !cs_n && act_n && ras_n && cas_n && we_n)
        else $error("latency lead cycle does not show bare chip select");
    AST_MRS_SPACE: assert property (@(posedge pclk) disable iff (!presetn) // RL4
        (issue && is_mrs) |=> state == ST_WAIT && cnt == $past(mrs_space))
        else $error("mode set spacing not loaded with delay plus latency");
    AST_MRS_NEXT: assert property (@(posedge pclk) disable iff (!presetn) // RL5
        (issue && is_mrs) |=> !issue [*8])
        else $error("command issued too soon after mode set");
    AST_SR_LOCK: assert property (@(posedge pclk) disable iff (!presetn) // RL9
        in_sr |-> !(issue && is_mrs))
        else $error("mode register set during self refresh");
    AST_NOP_WIN: assert property (@(posedge pclk) disable iff (!presetn) // RL11
        (nop_win && !cs_n) |-> act_n && ras_n && cas_n && we_n)
        else $error("non NOP command in exit window");
    AST_PRECHG: assert property (@(posedge pclk) disable iff (!presetn) // RL14
        (issue && mrs_acc && addr_reg[ddr_host_pkg::MPX_BIT]) |-> !banks_open)
        else $error("access mode entered with an open bank");
    AST_MPX_LEGAL: assert property (@(posedge pclk) disable iff (!presetn) // RL17
        (issue && mpx) |-> mpx_legal)
        else $error("illegal command in access mode");
    AST_MPX_NO_SR: assert property (@(posedge pclk) disable iff (!presetn) // RL19
        mpx |-> !(issue && (op == ddr_host_pkg::OP_SRE || op == ddr_host_pkg::OP_PDE)))
        else $error("power-down or self refresh in access mode");
    AST_MPX_BURST: assert property (@(posedge pclk) disable iff (!presetn) // RL23
        (issue && mpx && op == ddr_host_pkg::OP_RD) |-> col[1:0] == 2'h0)
        else $error("access mode read not burst 8 or chop 4");
    AST_REF_WAIT: assert property (@(posedge pclk) disable iff (!presetn) // RL20
        (issue && op == ddr_host_pkg::OP_REF) |=> cnt == ddr_host_pkg::CNT_W'(ddr_host_pkg::TRFC_CK))
        else $error("refresh wait not loaded");
    AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready)
        else $error("bus answer late");
    COV_CAL_MRS: cover property (@(posedge pclk) disable iff (!presetn) issue && is_mrs && cal_on);
    COV_NOP_EXIT: cover property (@(posedge pclk) disable iff (!presetn) nop_win && !cs_n);
    COV_MPX_READ: cover property (@(posedge pclk) disable iff (!presetn)
        issue && mpx && op == ddr_host_pkg::OP_RD);
    COV_REFUSE: cover property (@(posedge pclk) disable iff (!presetn) go && refuse);
endmodule // ddr_cmd_host

// File: hdl/ddr_host_pkg.sv
// Constants, command codes and register map of the memory command host
package ddr_host_pkg;
    // Register map, byte addresses of 32-bit words
    localparam logic [7:0] REG_CMD = 8'h00; // Write: opcode, starts a command
    localparam logic [7:0] REG_ADDR = 8'h04; // Address, bank, bank group
    localparam logic [7:0] REG_STATUS = 8'h08; // Read state, write 1 clears refused
    // Command register and address register fields
    localparam int OP_W = 4;
    localparam int ADDR_W = 17;
    localparam int BA_LSB = 17;
    localparam int BG_LSB = 19;
    // Status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_MPX = 2;
    localparam int ST_SELF_REF = 3;
    localparam int ST_PWR_DOWN = 4;
    localparam int ST_BANKS_OPEN = 5;
    localparam int ST_TEMP_LSB = 8;
    localparam int ST_CAL_LSB = 12;
    // Mode register numbers and fields inside the address word
    localparam logic [2:0] MR_BURST = 3'h0;
    localparam logic [2:0] MR_TEMP = 3'h2;
    localparam logic [2:0] MR_ACCESS = 3'h3;
    localparam logic [2:0] MR_LAT = 3'h4;
    localparam logic [2:0] MR_PARITY = 3'h5;
    localparam int BL_LSB = 0;
    localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
    localparam int TEMP_LSB = 6;
    localparam int MPX_BIT = 2;
    localparam int FGR_LSB = 6;
    localparam int CAL_LSB = 6;
    localparam int PAR_LSB = 0;
    localparam int DBI_RD_BIT = 12;
    localparam logic [2:0] BURST8_COL = 3'h0;
    localparam logic [2:0] CHOP4_COL = 3'h4;
    // Host commands
    typedef enum logic [3:0] {
        OP_DES, OP_NOP, OP_MRS, OP_REF, OP_PRE_ALL, OP_ACT, OP_RD, OP_WR,
        OP_SRE, OP_SRX, OP_PDE, OP_PDX, OP_RESET
    } host_op_e;
    // Wait figures in memory clock cycles, divider in pclk cycles
    localparam int TMOD_CK = 24; // Mode register update delay
    localparam int TRP_CK = 16; // Precharge time
    localparam int TRFC_CK = 64; // Refresh cycle time
    localparam int BURST_CK = 4; // Burst of 8 on the data bus
    localparam int EXIT_WIN_CK = 8; // Max power saving exit window
    localparam int RESET_CK = 32; // Reset pin held low
    localparam int CK_HALF = 2; // Pclk cycles per half memory clock
    localparam int CNT_W = 8;
endpackage

// File: bench/ddr_dev_model.sv
// Memory device model: decodes command pins and keeps the mode registers
`timescale 1ns/1ps
module ddr_dev_model (
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic act_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [16:0] addr,
    input wire logic [1:0] ba,
    input wire logic [1:0] bg,
    input wire logic reset_n,
    input wire logic por_n,
    output logic [1:0] temp_mode,
    output logic [1:0] sr_mode,
    output logic [2:0] lat_code,
    output logic mpx_on,
    output logic [15:0] nop_cnt,
    output logic [15:0] rd_cnt,
    output logic [15:0] viol_cnt
);
    logic [16:0] mr [0:7]; // Mode registers
    int lead; // Cycles until a latched select brings its command
    int gap; // Cycles since the last mode set's select
    logic cke_q; // Previous clock enable, shows self refresh entry
    wire [2:0] pins = {ras_n, cas_n, we_n};
    wire [3:0] lat = (lat_code == 3'h0) ? 4'h0 : (lat_code == 3'h5) ? 4'h8 :
        {1'b0, lat_code} + 4'h2;
    wire live = (lat == 4'h0) ? !cs_n : (lead == 1);
    wire valid = live && !(act_n && pins == 3'h7); // No-op and deselect excluded
    assign temp_mode = mr[2][7:6];
    assign lat_code = mr[4][8:6];
    assign mpx_on = mr[3][2];
    // Decode at the rising memory clock, where the host holds pins steady
    always @(posedge ck or negedge reset_n or negedge por_n) begin
        if (!reset_n || !por_n) begin
            foreach (mr[i]) mr[i] <= 17'h0;
            lead <= 0;
            gap <= 1000;
            cke_q <= 1'b1;
            sr_mode <= 2'h0;
            nop_cnt <= 16'h0;
            rd_cnt <= 16'h0;
            viol_cnt <= 16'h0;
        end else begin
            gap <= gap + 1;
            cke_q <= cke;
            if (lead > 0) begin
                lead <= lead - 1;
            end else if (lat != 4'h0 && !cs_n) begin
                lead <= int'(lat); // Receivers wake on select
            end
            if (cke_q && !cke) begin
                sr_mode <= temp_mode;
            end
            if (lat == 4'h0 && live && act_n && pins == 3'h7) begin
                nop_cnt <= nop_cnt + 16'h1;
            end
            // Spacing counted select to select, with the newest latency
            if (valid && gap + 1 < ddr_host_pkg::TMOD_CK + 2 * int'(lat)) begin
                viol_cnt <= viol_cnt + 16'h1;
            end
            if (valid && act_n && pins == 3'h0) begin
                mr[{bg[0], ba}] <= addr;
                gap <= int'(lat);
            end
            if (valid && act_n && pins == 3'h5) begin
                rd_cnt <= rd_cnt + 16'h1;
            end
        end
    end
endmodule // ddr_dev_model

// File: bench/tb_top.sv
// Bench top: APB driver, scenarios and verdict for the memory command host
`timescale 1ns/1ps
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b1; // Falls at the first edge so the model sees an edge
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, ck, cke, cs_n, act_n, ras_n, cas_n, we_n, reset_n, rerr, mpx_on;
    logic [16:0] addr;
    logic [1:0] ba, bg, temp_mode, sr_mode;
    logic [2:0] lat_code;
    logic [15:0] nop_cnt, rd_cnt, viol_cnt;
    int error_cnt = 0;
    int samples_checked = 0;
    always #2 pclk = ~pclk;
    ddr_cmd_host dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ck, .cke, .cs_n, .act_n, .ras_n, .cas_n, .we_n, .addr, .ba, .bg,
        .reset_n);
    ddr_dev_model mem (.ck, .cke, .cs_n, .act_n, .ras_n, .cas_n, .we_n, .addr, .ba, .bg,
        .reset_n, .por_n(presetn), .temp_mode, .sr_mode, .lat_code, .mpx_on, .nop_cnt,
        .rd_cnt, .viol_cnt);
    // Ends the run with counts and verdict
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            tally_and_finish();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Address word: mode register number in bank group and bank fields
    function logic [31:0] mrw(input logic [2:0] mr, input logic [16:0] a);
        return {12'h0, mr[2], mr[1:0], a};
    endfunction
    // Issue a command and poll busy under a bound
    task cmd(input logic [3:0] op, input logic [31:0] aw);
        int i;
        apb(1'b1, ddr_host_pkg::REG_ADDR, aw);
        apb(1'b1, ddr_host_pkg::REG_CMD, {28'h0, op});
        for (i = 0; i < 2000; i++) begin
            apb(1'b0, ddr_host_pkg::REG_STATUS, 32'h0);
            if (rdata[ddr_host_pkg::ST_BUSY] === 1'b0) break;
        end
        if (i == 2000) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    // Status bit check, optionally clearing the refused flag
    task stat(input string nm, input int b, input logic e);
        apb(1'b0, ddr_host_pkg::REG_STATUS, 32'h0);
        check(nm, 32'(rdata[b]), 32'(e));
        if (b == ddr_host_pkg::ST_REFUSED) apb(1'b1, ddr_host_pkg::REG_STATUS, 32'h2);
    endtask
    initial begin
        repeat (100000) @(posedge pclk);
        error_cnt++; // Hang guard
        tally_and_finish();
    end
    initial begin
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ddr_host_pkg::REG_STATUS, 32'h0);
        check("status", rdata, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check("slverr", 32'(rerr), 32'h1);
        $display("test reset done");
        for (int v = 0; v < 4; v++) begin
            cmd(ddr_host_pkg::OP_MRS, mrw(ddr_host_pkg::MR_TEMP, 17'(v << 6)));
            apb(1'b0, ddr_host_pkg::REG_STATUS, 32'h0);
            check("temp", 32'(rdata[ddr_host_pkg::ST_TEMP_LSB +: 2]), 32'(v));
            check("dev temp", 32'(temp_mode), 32'(v));
        end
        $display("test temp done");
        cmd(ddr_host_pkg::OP_MRS, mrw(ddr_host_pkg::MR_LAT, 17'h40));
        apb(1'b0, ddr_host_pkg::REG_STATUS, 32'h0);
        check("lat", 32'(rdata[ddr_host_pkg::ST_CAL_LSB +: 3]), 32'h1);
        check("dev lat", 32'(lat_code), 32'h1);
        cmd(ddr_host_pkg::OP_NOP, 32'h0);
        cmd(ddr_host_pkg::OP_MRS, mrw(ddr_host_pkg::MR_LAT, 17'h0));
        check("spacing", 32'(viol_cnt), 32'h0);
        $display("test latency done");
        cmd(ddr_host_pkg::OP_MRS, mrw(ddr_host_pkg::MR_TEMP, 17'h80));
        cmd(ddr_host_pkg::OP_SRE, 32'h0);
        stat("in self refresh", ddr_host_pkg::ST_SELF_REF, 1'b1);
        cmd(ddr_host_pkg::OP_SRX, 32'h0);
        stat("left self refresh", ddr_host_pkg::ST_SELF_REF, 1'b0);
        // Exit command is itself a no-op, then the rest of the window
        check("nops", 32'(nop_cnt), 32'(ddr_host_pkg::EXIT_WIN_CK));
        check("sr mode", 32'(sr_mode), 32'h2);
        $display("test self refresh done");
        cmd(ddr_host_pkg::OP_ACT, 32'h0);
        cmd(ddr_host_pkg::OP_MRS, mrw(ddr_host_pkg::MR_ACCESS, 17'h4));
        stat("open bank", ddr_host_pkg::ST_REFUSED, 1'b1);
        cmd(ddr_host_pkg::OP_PRE_ALL, 32'h0);
        cmd(ddr_host_pkg::OP_MRS, mrw(ddr_host_pkg::MR_ACCESS, 17'h4));
        stat("access", ddr_host_pkg::ST_MPX, 1'b1);
        cmd(ddr_host_pkg::OP_REF, 32'h0);
        stat("refresh taken", ddr_host_pkg::ST_REFUSED, 1'b0);
        cmd(ddr_host_pkg::OP_RD, 32'h1);
        stat("bad column", ddr_host_pkg::ST_REFUSED, 1'b1);
        cmd(ddr_host_pkg::OP_SRE, 32'h0);
        stat("sre refused", ddr_host_pkg::ST_REFUSED, 1'b1);
        cmd(ddr_host_pkg::OP_RD, 32'h0);
        cmd(ddr_host_pkg::OP_RD, 32'h4);
        check("reads", 32'(rd_cnt), 32'h2);
        cmd(ddr_host_pkg::OP_RESET, 32'h0);
        apb(1'b0, ddr_host_pkg::REG_STATUS, 32'h0);
        check("after reset", rdata, 32'h0);
        check("dev mode", 32'(mpx_on), 32'h0);
        $display("test access mode done");
        tally_and_finish();
    end
endmodule // tb_top
